// ### hdl/scan_defines.vh
`ifndef SCAN_DEFINES_VH
`define SCAN_DEFINES_VH
`define ADDR_SEL_A      8'h00
`define ADDR_SEL_B      8'h01
`define ADDR_SEL_C      8'h02
`define ADDR_SEL_D      8'h03
`define ADDR_CTRL       8'h04
`define ADDR_STATUS     8'h05
`define ADDR_INT_EN     8'h06
`define ADDR_INT_CLR    8'h07
`define ADDR_RES_BASE   8'h10
`define ADDR_RES_MASK   8'hf0
`define CTRL_NUM_LO     0
`define CTRL_NUM_HI     2
`define CTRL_SCAN       3
`define CTRL_REPEAT_CONVERSION       4
`define CTRL_ALIGN      5
`define CTRL_ENABLE     6
`define ST_DONE         0
`define ST_SLOT         1
`define ST_BITS         2
`define RESET_BYTE      8'h00
`define RESET_WORD      16'h0000
`define NIBBLE_ZERO     4'h0
`define SLOT_ZERO       3'h0
`define SLOT_ONE        3'h1
`define SLOT_LAST       3'h7
`endif

// ### hdl/result_align.v
`timescale 1ns/1ns
`include "scan_defines.vh"
module result_align (
  input  wire        align_right,
  input  wire        ten_bit,
  input  wire [11:0] raw,
  output reg  [15:0] word
);
  always @* begin
    if (align_right) begin
      // Right: low byte full, top four bits (two when ten_bit) in high byte
      if (ten_bit)
        word = {6'h00, raw[9:0]};
      else
        word = {4'h0, raw};
    end else begin
      // Left: high byte full, rest in low nibble
      if (ten_bit)
        word = {raw[9:2], 6'h00, raw[1:0]};
      else
        word = {raw[11:4], 4'h0, raw[3:0]};
    end
  end
endmodule // result_align

// ### hdl/slot_decode.v
`timescale 1ns/1ns
`include "scan_defines.vh"
module slot_decode (
  input  wire [31:0] sel_flat,
  input  wire [2:0]  slot,
  output wire [3:0]  channel
);
  // Slot n uses nibble n: even low, odd high
  assign channel = sel_flat[{slot, 2'b00} +: 4];
endmodule // slot_decode

// ### hdl/adc_scan_channel_and_result_buffer.v
`timescale 1ns/1ns
`include "scan_defines.vh"
module adc_scan_channel_and_result_buffer (
  input  wire        clk,
  input  wire        resetn,
  input  wire        ce,
  input  wire [7:0]  addr,
  input  wire [7:0]  wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [7:0]  rdata,
  input  wire        scan_start,
  input  wire        ten_bit,
  output reg  [3:0]  mux_select,
  output reg         conv_start,
  input  wire        conv_done,
  input  wire [11:0] conv_result,
  output reg         scan_busy,
  output wire        irq
);
  localparam IDLE = 3'b001;
  localparam CONV = 3'b010;
  localparam WAIT = 3'b100;

  reg  [7:0]  sel_reg [0:3];
  reg  [15:0] result [0:7];
  reg  [6:0]  ctrl;
  reg  [2:0]  status;
  reg  [2:0]  int_en;
  reg  [2:0]  state;
  reg  [2:0]  slot;
  wire [31:0] sel_flat;
  wire [3:0]  channel;
  wire [15:0] aligned;
  wire [2:0]  num;
  wire        enable;
  wire        scan_on;
  wire        last_slot;
  wire        pass_end;
  wire        bad_sel;
  reg  [2:0]  ev;
  reg  [7:0]  next_rdata;
  integer     i;

  assign num     = ctrl[`CTRL_NUM_HI:`CTRL_NUM_LO];
  assign enable  = ctrl[`CTRL_ENABLE];
  assign scan_on = ctrl[`CTRL_SCAN];
  assign sel_flat = {sel_reg[3], sel_reg[2], sel_reg[1], sel_reg[0]};
  // Count field zero means eight, so a full pass is reachable
  assign last_slot = (slot == (num - `SLOT_ONE));
  assign pass_end  = (state == WAIT) && conv_done && last_slot;
  assign bad_sel   = wr && addr == `ADDR_CTRL && !wdata[`CTRL_SCAN]
                     && scan_busy;
  assign irq = |(status & int_en);

  slot_decode u_dec (
    .sel_flat (sel_flat),
    .slot     (slot),
    .channel  (channel)
  );

  result_align u_align (
    .align_right (ctrl[`CTRL_ALIGN]),
    .ten_bit     (ten_bit),
    .raw         (conv_result),
    .word        (aligned)
  );

  always @* begin
    ev = 3'h0;
    ev[`ST_DONE] = pass_end;
    ev[`ST_SLOT] = (state == WAIT) && conv_done;
    ev[`ST_BITS] = bad_sel;
  end

  always @(posedge clk) begin
    if (!resetn) begin
      for (i = 0; i < 4; i = i + 1)
        sel_reg[i] <= `RESET_BYTE;
      for (i = 0; i < 8; i = i + 1)
        result[i] <= `RESET_WORD;
      ctrl       <= 7'h00;
      status     <= 3'h0;
      int_en     <= 3'h0;
      state      <= IDLE;
      slot       <= `SLOT_ZERO;
      mux_select <= `NIBBLE_ZERO;
      conv_start <= 1'b0;
      scan_busy  <= 1'b0;
      rdata      <= `RESET_BYTE;
    end else if (ce) begin
      rdata      <= next_rdata;
      conv_start <= 1'b0;
      if (wr) begin
        if (addr[7:2] == 6'h00)
          sel_reg[addr[1:0]] <= wdata;
        if (addr == `ADDR_CTRL) begin
          // Scan bit held while a pass runs
          ctrl <= wdata[6:0];
          if (scan_busy)
            ctrl[`CTRL_SCAN] <= 1'b1;
        end
        if (addr == `ADDR_INT_EN)
          int_en <= wdata[2:0];
      end
      // Set wins over clear
      status <= (status & ~((wr && addr == `ADDR_INT_CLR) ? wdata[2:0]
                : 3'h0)) | ev;
      case (state)
        IDLE: begin
          if (enable && scan_on && scan_start) begin
            slot       <= `SLOT_ZERO;
            mux_select <= sel_flat[3:0];
            conv_start <= 1'b1;
            scan_busy  <= 1'b1;
            state      <= WAIT;
          end
        end
        CONV: begin
          mux_select <= channel;
          conv_start <= 1'b1;
          state      <= WAIT;
        end
        WAIT: begin
          if (!enable) begin
            // Enable off aborts the pass
            scan_busy <= 1'b0;
            state     <= IDLE;
          end else if (conv_done) begin
            result[slot] <= aligned;
            if (last_slot) begin
              slot <= `SLOT_ZERO;
              if (ctrl[`CTRL_REPEAT_CONVERSION]) begin
                state <= CONV;
              end else begin
                scan_busy <= 1'b0;
                state     <= IDLE;
              end
            end else begin
              slot  <= slot + `SLOT_ONE;
              state <= CONV;
            end
          end
        end
        default: state <= IDLE;
      endcase
    end
  end

  always @* begin
    next_rdata = `RESET_BYTE;
    if (rd) begin
      if ((addr & `ADDR_RES_MASK) == `ADDR_RES_BASE) begin
        // Odd address high byte, even low byte
        if (addr[0])
          next_rdata = result[addr[3:1]][15:8];
        else
          next_rdata = result[addr[3:1]][7:0];
      end else begin
        case (addr)
          `ADDR_SEL_A:   next_rdata = sel_reg[0];
          `ADDR_SEL_B:   next_rdata = sel_reg[1];
          `ADDR_SEL_C:   next_rdata = sel_reg[2];
          `ADDR_SEL_D:   next_rdata = sel_reg[3];
          `ADDR_CTRL:    next_rdata = {1'b0, ctrl};
          `ADDR_STATUS:  next_rdata = {scan_busy, slot, 1'b0, status};
          `ADDR_INT_EN:  next_rdata = {5'h00, int_en};
          default:       next_rdata = `RESET_BYTE;
        endcase
      end
    end
  end
endmodule // adc_scan_channel_and_result_buffer

// ### dv/conv_model.sv
`timescale 1ns/1ns
module conv_model (
  input  wire       clk,
  input  wire       conv_start,
  input  wire [3:0] mux_select,
  output reg        conv_done = 1'b0,
  output reg [11:0] conv_result = 12'h000
);
  reg [3:0] ch = 4'h0;
  reg [2:0] t = 3'h0;
  // Idle result bus toggles so stale data never matches
  always @(posedge clk) begin
    conv_done <= t == 3'h1;
    conv_result <= t == 3'h1 ? {ch, ~ch, ch} : ~conv_result;
    t <= conv_start ? 3'h5 : t - {2'h0, t != 3'h0};
    if (conv_start) ch <= mux_select;
  end
endmodule // conv_model

// ### dv/scan_checker_assertions.sv
`timescale 1ns/1ns
module scan_checker (
  input wire       clk,
  input wire       resetn,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire       wr,
  input wire       rd,
  input wire [7:0] rdata,
  input wire       scan_start,
  input wire [3:0] mux_select,
  input wire       conv_start,
  input wire       conv_done,
  input wire       scan_busy,
  input wire       irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  start_gap_a: assert property (conv_start |=> !conv_start [*2])
    else $error("start too soon");
  start_busy_a: assert property (conv_start |-> scan_busy)
    else $error("start while idle");
  busy_cause_a: assert property ($rose(scan_busy) |-> $past(scan_start))
    else $error("busy without start");
  mux_hold_a: assert property ($changed(mux_select) |-> conv_start)
    else $error("mux moved");
  next_slot_a: assert property (conv_done && scan_busy |=>
    ##1 (conv_start || !scan_busy)) else $error("slot stalled");
  read_idle_a: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("stray read data");
  sel_back_a: assert property (wr && addr < 8'h04 ##1 !wr
    ##1 rd && addr == $past(addr, 2) |=> rdata == $past(wdata, 3))
    else $error("selector readback");
  irq_reset_a: assert property ($rose(resetn) |-> !irq)
    else $error("irq after reset");
endmodule // scan_checker
bind adc_scan_channel_and_result_buffer scan_checker scan_checker_inst (.*);

// ### dv/tb_top.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; \
  $display("FAIL %s exp %h got %h", n, e, g); end end
module tb_top;
  reg clk = 1'b0;
  reg resetn = 1'b0;
  reg [7:0] addr = 8'h00;
  reg [7:0] wdata = 8'h00;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg scan_start = 1'b0;
  wire [7:0] rdata;
  wire [3:0] mux_select;
  wire [11:0] conv_result;
  wire conv_start, conv_done, scan_busy, irq;
  int err_count = 0, n_tests = 0, k = 0, cyc = 0;
  reg [7:0] sv [4] = '{8'hfe, 8'h21, 8'hba, 8'h98};
  always #2 clk = ~clk;
  adc_scan_channel_and_result_buffer adc_scan_channel_and_result_buffer_inst (
    .ce(1'b1), .ten_bit(1'b0), .*);
  conv_model conv_model_inst (.*);
  function [3:0] ch(input int n);
    ch = sv[n / 2][4 * (n % 2) +: 4];
  endfunction
  function [7:0] res(input int n, input bit r, input bit h);
    reg [15:0] v;
    v = r ? {4'h0, ch(n), ~ch(n), ch(n)} : {ch(n), ~ch(n), 4'h0, ch(n)};
    res = h ? v[15:8] : v[7:0];
  endfunction
  task results;
    if (err_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task wreg(input [7:0] a, input [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rchk(input [7:0] a, input [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 `CHK("rdata", e, rdata)
  endtask
  // Scan bit is never cleared mid-pass; the pass runs to its end
  task scan(input [7:0] c);
    wreg(8'h04, c);
    k = 0;
    scan_start <= 1'b1;
    @(posedge clk);
    scan_start <= 1'b0;
    #1;
    for (int i = 0; i < 400 && scan_busy !== 1'b0; i++) @(posedge clk);
    #1;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      results;
    end
    if (resetn && conv_start === 1'b1) begin
      `CHK("mux_select", ch(k), mux_select)
      k = k + 1;
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rchk(8'(i), 8'h00);
      wreg(8'(i), sv[i]);
      rchk(8'(i), sv[i]);
    end
    rchk(8'h08, 8'h00);
    wreg(8'h06, 8'h01);
    scan(8'h48);
    `CHK("slots", 8, k)
    `CHK("irq", 1'b1, irq)
    wreg(8'h07, 8'h01);
    #1 `CHK("irq", 1'b0, irq)
    scan(8'h6b);
    `CHK("slots", 3, k)
    wreg(8'h10, 8'hff);
    for (int i = 0; i < 8; i++) begin
      rchk(8'(16 + 2 * i), res(i, i < 3, 1'b0));
      rchk(8'(17 + 2 * i), res(i, i < 3, 1'b1));
    end
    results;
  end
endmodule // tb_top
